// *** verilog/pmc_mode_ctrl.sv ***
/*
 * pmc_mode_ctrl: mode sequencing and front-panel indication of the
 * controller CPU.
 * Assumes synchronous status inputs from the program engine, memory
 * clearer and serial ports; the switches are raw contacts.
 */
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl #(
    parameter int unsigned DEBOUNCE_CYC = pmc_pkg::DEBOUNCE_CYC,
    parameter int unsigned SLOW_CYC = pmc_pkg::SLOW_FLASH_CYC,
    parameter int unsigned FAST_CYC = pmc_pkg::FAST_FLASH_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // front switches (raw): mode 1 = RUN; momentary down / up contacts
    input wire logic mode_run_raw,
    input wire logic mc_down_raw,
    input wire logic mc_up_raw,
    // stop sources
    input wire logic pg_stop_req,
    input wire logic peer_stop_req,
    input wire logic self_stop_req,
    input wire logic self_overall_req,
    // program engine and memory clearer handshakes
    input wire logic check_done,
    input wire logic ram_clear_done,
    input wire logic scan_end,
    input wire logic [31:0] cycle_limit,
    // process interrupt from the backplane
    input wire logic proc_int,
    input wire logic int_handler_done,
    // fault reports
    input wire logic io_ack_missing,
    input wire logic [7:0] io_ack_byte,
    input wire logic [127:0] present_map,
    input wire logic io_addr_empty,
    input wire logic first_serial_port_fail,
    input wire logic second_serial_port_fail,
    input wire logic second_serial_port_bad_cfg,
    // program engine control
    output logic prog_run,
    output logic prog_from_start,
    output logic ram_clear,
    output logic state_clear,
    output logic [7:0] block_call,
    output logic int_active,
    // indicators
    output logic run_led,
    output logic stop_led,
    output logic ack_timeout_indicator,
    output logic address_error_indicator,
    output logic cycle_time_indicator,
    output logic first_serial_port_led,
    output logic second_serial_port_led
);
    typedef struct packed {
        pmc_pkg::pmc_state_e state;
        pmc_pkg::pmc_led_e stop_mode;
        logic overall_pend;
        logic clearing;
        logic [4:0] phase_cnt;
        logic [31:0] flash_cnt;
        logic flash_slow;
        logic flash_fast;
        logic [31:0] scan_cnt;
        logic run_led;
        logic stop_led;
        logic prog_run;
        logic prog_out;
        logic prog_from_start;
        logic ram_clear;
        logic state_clear;
        logic [7:0] block_call;
        logic int_active;
        logic ack_to;
        logic addr_err;
        logic cyc_err;
        logic si1;
        logic si2;
    } pmc_top_s;

    pmc_top_s st_ff;
    pmc_top_s nxt_st;

    pmc_sw_if mode_sw ();
    pmc_sw_if down_sw ();
    pmc_sw_if up_sw ();

    // ------------------------------------------------------------------
    // contact filters
    // ------------------------------------------------------------------
    pmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_mode (
        .clk(clk), .rst(rst), .raw(mode_run_raw), .sw(mode_sw)
    );
    pmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_down (
        .clk(clk), .rst(rst), .raw(mc_down_raw), .sw(down_sw)
    );
    pmc_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_up (
        .clk(clk), .rst(rst), .raw(mc_up_raw), .sw(up_sw)
    );

    logic ack_present;
    assign ack_present = (io_ack_byte <= pmc_pkg::IMAGE_LAST_BYTE) && present_map[io_ack_byte[6:0]];

    // ------------------------------------------------------------------
    // sequencing, indication and fault latching
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.block_call = pmc_pkg::NO_BLOCK;
        nxt_st.state_clear = 1'b0;
        nxt_st.prog_from_start = 1'b0;
        // free-running flash timebase; both rates from one counter
        nxt_st.flash_cnt = st_ff.flash_cnt + 32'h0000_0001;
        if (st_ff.flash_cnt >= 32'(SLOW_CYC - 1)) begin
            nxt_st.flash_cnt = 32'h0000_0000;
            nxt_st.flash_slow = ~st_ff.flash_slow;
        end
        if (st_ff.flash_cnt % 32'(FAST_CYC) == 32'(FAST_CYC - 1)) begin
            nxt_st.flash_fast = ~st_ff.flash_fast;
        end
        unique case (st_ff.state)
            pmc_pkg::PMC_INIT: begin
                nxt_st.phase_cnt = st_ff.phase_cnt + 5'h01;
                if (st_ff.phase_cnt == 5'(pmc_pkg::INIT_CYC - 1)) begin
                    nxt_st.phase_cnt = 5'h00;
                    nxt_st.state = pmc_pkg::PMC_STOP;
                    nxt_st.overall_pend = 1'b1; // power-up asks for overall reset
                end
            end
            pmc_pkg::PMC_CHECK: begin
                if (check_done) begin
                    nxt_st.state = pmc_pkg::PMC_RUN;
                    nxt_st.prog_run = 1'b1;
                    nxt_st.scan_cnt = 32'h0000_0000;
                end
            end
            pmc_pkg::PMC_STOP: begin
                if (down_sw.level && !mode_sw.level) begin
                    nxt_st.overall_pend = 1'b1;
                end
                if (st_ff.clearing) begin
                    if (ram_clear_done) begin
                        nxt_st.clearing = 1'b0;
                        nxt_st.ram_clear = 1'b0;
                        nxt_st.overall_pend = 1'b0;
                        nxt_st.stop_mode = pmc_pkg::PMC_LED_ON;
                    end
                end else if (mode_sw.rise) begin
                    if (down_sw.level) begin
                        nxt_st.clearing = 1'b1;
                        nxt_st.ram_clear = 1'b1;
                    end else if (!st_ff.overall_pend) begin
                        if (up_sw.level) begin
                            nxt_st.state_clear = 1'b1;
                            nxt_st.prog_from_start = 1'b1;
                            nxt_st.block_call = pmc_pkg::RESET_STARTUP_BLOCK;
                        end
                        // midpoint keeps flags, timers and image untouched
                        nxt_st.state = pmc_pkg::PMC_CHECK;
                    end
                end
                if (mode_sw.fall && st_ff.stop_mode == pmc_pkg::PMC_LED_SLOW) begin
                    nxt_st.stop_mode = pmc_pkg::PMC_LED_ON;
                end
            end
            pmc_pkg::PMC_RUN: begin
                nxt_st.scan_cnt = st_ff.scan_cnt + 32'h0000_0001;
                if (scan_end) begin
                    nxt_st.scan_cnt = 32'h0000_0000;
                end
                if (st_ff.scan_cnt > cycle_limit) begin
                    nxt_st.cyc_err = 1'b1;
                end
                if (proc_int && !st_ff.int_active) begin
                    nxt_st.int_active = 1'b1;
                    nxt_st.block_call = pmc_pkg::INT_HANDLER_BLOCK;
                end else if (int_handler_done) begin
                    nxt_st.int_active = 1'b0;
                end
                if (self_stop_req || self_overall_req) begin
                    nxt_st.state = pmc_pkg::PMC_STOP;
                    nxt_st.stop_mode = pmc_pkg::PMC_LED_SLOW;
                end else if (mode_sw.fall || pg_stop_req || peer_stop_req) begin
                    nxt_st.state = pmc_pkg::PMC_STOP;
                    nxt_st.stop_mode = pmc_pkg::PMC_LED_ON;
                end
                if (nxt_st.state == pmc_pkg::PMC_STOP) begin
                    nxt_st.prog_run = 1'b0;
                    nxt_st.int_active = 1'b0;
                end
            end
        endcase
        // a cpu request after the case, so it wins over the end of a clear
        if (self_overall_req) begin
            nxt_st.overall_pend = 1'b1;
        end
        // the interrupt flag is only held in run; interrupt pauses the scan
        if (nxt_st.state != pmc_pkg::PMC_RUN) begin
            nxt_st.int_active = 1'b0;
        end
        // registered scan enable so the output needs no gate after the flop
        nxt_st.prog_out = nxt_st.prog_run && !nxt_st.int_active;
        // a fresh reset re-arms the fault lamps
        if (nxt_st.state_clear || nxt_st.ram_clear) begin
            nxt_st.ack_to = 1'b0;
            nxt_st.addr_err = 1'b0;
            nxt_st.cyc_err = 1'b0;
        end
        if (io_ack_missing && ack_present) begin
            nxt_st.ack_to = 1'b1;
        end
        if (io_addr_empty) begin
            nxt_st.addr_err = 1'b1;
        end
        nxt_st.si1 = first_serial_port_fail;
        nxt_st.si2 = second_serial_port_fail || second_serial_port_bad_cfg;
        // lamps: RUN only in run, STOP pattern chosen by stop cause
        nxt_st.run_led = (nxt_st.state == pmc_pkg::PMC_RUN);
        unique case (nxt_st.state)
            pmc_pkg::PMC_INIT, pmc_pkg::PMC_CHECK: nxt_st.stop_led = 1'b0;
            pmc_pkg::PMC_RUN: nxt_st.stop_led = 1'b0;
            pmc_pkg::PMC_STOP: begin
                if (nxt_st.overall_pend) begin
                    nxt_st.stop_led = nxt_st.flash_fast;
                end else if (nxt_st.stop_mode == pmc_pkg::PMC_LED_SLOW) begin
                    nxt_st.stop_led = nxt_st.flash_slow;
                end else begin
                    nxt_st.stop_led = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{state: pmc_pkg::PMC_INIT, stop_mode: pmc_pkg::PMC_LED_ON, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------------
    assign prog_run = st_ff.prog_out;
    assign prog_from_start = st_ff.prog_from_start;
    assign ram_clear = st_ff.ram_clear;
    assign state_clear = st_ff.state_clear;
    assign block_call = st_ff.block_call;
    assign int_active = st_ff.int_active;
    assign run_led = st_ff.run_led;
    assign stop_led = st_ff.stop_led;
    assign ack_timeout_indicator = st_ff.ack_to;
    assign address_error_indicator = st_ff.addr_err;
    assign cycle_time_indicator = st_ff.cyc_err;
    assign first_serial_port_led = st_ff.si1;
    assign second_serial_port_led = st_ff.si2;
endmodule
`default_nettype wire

// *** verilog/pmc_pkg.sv ***
/*
 * pmc_pkg: constants and types for the controller mode and status block.
 * Assumes a 250 MHz clock; switch inputs are raw contacts, synchronised by pmc_debounce.
 */
package pmc_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned DEBOUNCE_US = 10;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam int unsigned SLOW_FLASH_MS = 500;
    localparam int unsigned SLOW_FLASH_CYC = SLOW_FLASH_MS * 1000 * CLK_MHZ;
    localparam int unsigned FAST_FLASH_MS = 125;
    localparam int unsigned FAST_FLASH_CYC = FAST_FLASH_MS * 1000 * CLK_MHZ;
    localparam int unsigned INIT_CYC = 16;
    localparam int unsigned CHECK_CYC = 16;

    // ------------------------------------------------------------------
    // block numbers and image bound
    // ------------------------------------------------------------------
    localparam logic [7:0] INT_HANDLER_BLOCK = 8'h02;
    localparam logic [7:0] RESET_STARTUP_BLOCK = 8'h14;
    localparam logic [7:0] IMAGE_LAST_BYTE = 8'h7f;
    localparam logic [7:0] NO_BLOCK = 8'h00;

    // momentary switch positions
    typedef enum logic [1:0] {
        PMC_MC_RESTART = 2'b00,
        PMC_MC_RESET = 2'b01,
        PMC_MC_OVERALL = 2'b10
    } pmc_mc_e;

    typedef enum {
        PMC_INIT, PMC_CHECK, PMC_STOP, PMC_RUN
    } pmc_state_e;

    typedef enum logic [1:0] {
        PMC_LED_OFF = 2'b00,
        PMC_LED_ON = 2'b01,
        PMC_LED_SLOW = 2'b10,
        PMC_LED_FAST = 2'b11
    } pmc_led_e;
endpackage

// *** verilog/pmc_sw_if.sv ***
/*
 * pmc_sw_if: carries one debounced switch level plus its change pulses.
 * Assumes a single clock domain shared by filter and consumer.
 */
`timescale 1ns/1ps
`default_nettype none
interface pmc_sw_if;
    logic level;
    logic rise;
    logic fall;
    modport filt (output level, output rise, output fall);
    modport user (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** verilog/pmc_debounce.sv ***
/*
 * pmc_debounce: two-stage synchroniser and stability filter for one contact.
 * Assumes a raw mechanical input; reports level and one-cycle edges.
 */
`timescale 1ns/1ps
`default_nettype none
module pmc_debounce #(
    parameter int unsigned STABLE_CYC = pmc_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw contact
    input wire logic raw,
    // filtered view
    pmc_sw_if.filt sw
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic lvl;
        logic rise;
        logic fall;
        logic [15:0] cnt;
    } pmc_db_s;

    pmc_db_s st_ff;
    pmc_db_s nxt_st;

    // ------------------------------------------------------------------
    // filter: level only changes after it has stayed put STABLE_CYC cycles
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.rise = 1'b0;
        nxt_st.fall = 1'b0;
        if (st_ff.s2 == st_ff.lvl) begin
            nxt_st.cnt = 16'h0000;
        end else if (st_ff.cnt >= 16'(STABLE_CYC - 1)) begin
            nxt_st.cnt = 16'h0000;
            nxt_st.lvl = st_ff.s2;
            nxt_st.rise = st_ff.s2;
            nxt_st.fall = ~st_ff.s2;
        end else begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sw.level = st_ff.lvl;
    assign sw.rise = st_ff.rise;
    assign sw.fall = st_ff.fall;
endmodule
`default_nettype wire

// *** tb/pmc_mode_checker.sv ***
/* pmc_mode_checker: port-level checks on the mode and status block.
   Assumes one clock with async active-high reset; bound into pmc_mode_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched inputs
    input wire logic ram_clear_done,
    input wire logic io_addr_empty,
    input wire logic first_serial_port_fail,
    // watched outputs
    input wire logic prog_run,
    input wire logic prog_from_start,
    input wire logic ram_clear,
    input wire logic state_clear,
    input wire logic [7:0] block_call,
    input wire logic int_active,
    input wire logic run_led,
    input wire logic stop_led,
    input wire logic address_error_indicator,
    input wire logic first_serial_port_led
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_int_handler_call: assert property ($rose(int_active) |-> block_call == pmc_pkg::INT_HANDLER_BLOCK)
        else $error("interrupt entry without handler call");
    a_int_halts_scan: assert property (int_active |-> !prog_run)
        else $error("scan runs during interrupt");
    a_reset_startup_call: assert property (state_clear |-> prog_from_start && block_call == 8'h14)
        else $error("reset without startup call");
    a_clear_holds: assert property (ram_clear && !ram_clear_done |=> ram_clear)
        else $error("memory clear dropped early");
    a_clear_ends_steady: assert property (ram_clear && ram_clear_done |=> !ram_clear && stop_led)
        else $error("memory clear end wrong");
    a_lamps_exclusive: assert property (run_led |-> !stop_led)
        else $error("both lamps lit");
    // init phase lasts longer than eight cycles, so both lamps stay dark
    a_init_dark: assert property ($fell(rst) |-> (!run_led && !stop_led) [*8])
        else $error("lamp lit during init");
    a_addr_lamp: assert property (io_addr_empty |=> address_error_indicator)
        else $error("address error lamp not set");
    a_serial_follow: assert property (!$past(rst) |-> first_serial_port_led == $past(first_serial_port_fail))
        else $error("serial lamp does not follow");
endmodule
bind pmc_mode_ctrl pmc_mode_checker pmc_mode_checker_inst (.clk, .rst, .ram_clear_done, .io_addr_empty,
    .first_serial_port_fail, .prog_run, .prog_from_start, .ram_clear, .state_clear, .block_call, .int_active,
    .run_led, .stop_led, .address_error_indicator, .first_serial_port_led);
`default_nettype wire

// *** tb/pmc_far_model.sv ***
/* pmc_far_model: memory clearer, program checker, handler and backplane source.
   Assumes the block's clock; answers each open job within six cycles. */
`timescale 1ns/1ps
`default_nettype none
module pmc_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // jobs from the block and the bench
    input wire logic ram_clear,
    input wire logic int_active,
    input wire logic chk_go,
    input wire logic fire_int,
    // answers
    output logic ram_clear_done,
    output logic check_done,
    output logic int_handler_done,
    output logic proc_int
);
    logic [2:0] cnt_ff;
    wire logic due = (cnt_ff == 3'd5);
    // one shared counter; jobs that overlap are all answered on the same count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 3'd0;
            ram_clear_done <= 1'b0;
            check_done <= 1'b0;
            int_handler_done <= 1'b0;
        end else begin
            cnt_ff <= ((ram_clear || int_active || chk_go) && !due) ? cnt_ff + 3'd1 : 3'd0;
            ram_clear_done <= due && ram_clear;
            check_done <= due && chk_go;
            int_handler_done <= due && int_active;
        end
    end
    // interrupt-capable input module wired to this slot's line
    assign proc_int = fire_int;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/* tb: self-checking bench for the mode and status block.
   Assumes shortened debounce and flash counts; partner model answers jobs. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, mode_run_raw = 1'b0, mc_down_raw = 1'b0, mc_up_raw = 1'b0;
    logic pg_stop_req = 1'b0, peer_stop_req = 1'b0, self_stop_req = 1'b0, self_overall_req = 1'b0;
    logic scan_end = 1'b0, io_ack_missing = 1'b0, io_addr_empty = 1'b0, fire_int = 1'b0, chk_go = 1'b0;
    logic first_serial_port_fail = 1'b0, second_serial_port_fail = 1'b0, second_serial_port_bad_cfg = 1'b0;
    logic [31:0] cycle_limit = 32'h0000_1388;
    logic [7:0] io_ack_byte = 8'h00;
    logic [127:0] present_map = 128'h0000_0000_0000_0000_0000_0000_0000_0020;
    logic check_done, ram_clear_done, proc_int, int_handler_done, prog_run, prog_from_start, ram_clear;
    logic state_clear, int_active, run_led, stop_led, ack_timeout_indicator, address_error_indicator;
    logic cycle_time_indicator, first_serial_port_led, second_serial_port_led, rc_q, sl_q;
    logic [7:0] block_call;
    int n_mismatch = 0, total_checks = 0, n_sc = 0, n14 = 0, n02 = 0, n_rc = 0, n_edge = 0, e;
    always #2 clk = ~clk;
    pmc_mode_ctrl #(.DEBOUNCE_CYC(4), .SLOW_CYC(64), .FAST_CYC(16)) pmc_mode_ctrl_inst (.clk, .rst,
        .mode_run_raw, .mc_down_raw, .mc_up_raw, .pg_stop_req, .peer_stop_req, .self_stop_req,
        .self_overall_req, .check_done, .ram_clear_done, .scan_end, .cycle_limit, .proc_int, .int_handler_done,
        .io_ack_missing, .io_ack_byte, .present_map, .io_addr_empty, .first_serial_port_fail,
        .second_serial_port_fail, .second_serial_port_bad_cfg, .prog_run, .prog_from_start, .ram_clear,
        .state_clear, .block_call, .int_active, .run_led, .stop_led, .ack_timeout_indicator,
        .address_error_indicator, .cycle_time_indicator, .first_serial_port_led, .second_serial_port_led);
    pmc_far_model pmc_far_model_inst (.clk, .rst, .ram_clear, .int_active, .chk_go, .fire_int,
        .ram_clear_done, .check_done, .int_handler_done, .proc_int);
    // ------------------------------------------------------------
    // event counters: pulses are one cycle wide, so count them here
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (state_clear === 1'b1) n_sc++;
        if (block_call === 8'h14) n14++;
        if (block_call === 8'h02) n02++;
        if (ram_clear === 1'b1 && rc_q !== 1'b1) n_rc++;
        if (stop_led !== sl_q) n_edge++;
        rc_q = ram_clear;
        sl_q = stop_led;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // edge count of the stop lamp over 130 cycles tells steady, slow and fast apart
    task automatic flash();
        n_edge = 0;
        cyc(130);
        e = n_edge;
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_init();
        cyc(2);
        chk("init_lamps", 0, {run_led, stop_led});
        cyc(30);
        flash();
        chk("fast_flash", 1, e >= 6);
    endtask
    task automatic t_overall();
        mc_down_raw = 1'b1;
        cyc(10);
        mode_run_raw = 1'b1;
        cyc(40);
        chk("clear_runs", 1, n_rc);
        flash();
        chk("steady_edges", 0, e);
        chk("lamps", 1, {run_led, stop_led});
        mc_down_raw = 1'b0;
    endtask
    task automatic t_reset();
        chk_go = 1'b1;
        mode_run_raw = 1'b0;
        cyc(20);
        mc_up_raw = 1'b1;
        cyc(10);
        mode_run_raw = 1'b1;
        cyc(40);
        mc_up_raw = 1'b0;
        chk("clears", 1, n_sc);
        chk("startup_calls", 1, n14);
        chk("run_lamps", 2, {run_led, stop_led});
        chk("prog_run", 1, prog_run);
    endtask
    task automatic t_int();
        fire_int = 1'b1;
        cyc(2);
        fire_int = 1'b0;
        cyc(20);
        chk("handler_calls", 1, n02);
        chk("resumed", 2, {prog_run, int_active});
    endtask
    task automatic t_faults();
        io_ack_byte = 8'hc8;
        pulse(io_ack_missing);
        io_ack_byte = 8'h06;
        pulse(io_ack_missing);
        chk("ack_absent", 0, ack_timeout_indicator);
        io_ack_byte = 8'h05;
        pulse(io_ack_missing);
        chk("ack_present", 1, ack_timeout_indicator);
        pulse(io_addr_empty);
        chk("addr_lamp", 1, address_error_indicator);
        first_serial_port_fail = 1'b1;
        second_serial_port_bad_cfg = 1'b1;
        cyc(2);
        chk("serial_fail", 3, {first_serial_port_led, second_serial_port_led});
        first_serial_port_fail = 1'b0;
        second_serial_port_bad_cfg = 1'b0;
        second_serial_port_fail = 1'b1;
        cyc(2);
        chk("serial_second", 1, {first_serial_port_led, second_serial_port_led});
        second_serial_port_fail = 1'b0;
        cyc(2);
        chk("serial_ready", 0, {first_serial_port_led, second_serial_port_led});
        chk("cycle_quiet", 0, cycle_time_indicator);
        cycle_limit = 32'h0000_0003;
        pulse(scan_end);
        cyc(10);
        pulse(scan_end);
        chk("cycle_over", 1, cycle_time_indicator);
    endtask
    task automatic t_stops();
        pulse(peer_stop_req);
        cyc(2);
        chk("peer_stop", 1, {run_led, stop_led});
        flash();
        chk("peer_steady", 0, e);
        mode_run_raw = 1'b0;
        cyc(20);
        mode_run_raw = 1'b1;
        cyc(40);
        chk("restart_keeps", 1, n_sc);
        chk("restart_run", 2, {run_led, stop_led});
        mode_run_raw = 1'b0;
        cyc(20);
        chk("mode_stop", 1, {run_led, stop_led});
        mode_run_raw = 1'b1;
        cyc(40);
        pulse(self_stop_req);
        flash();
        chk("slow_flash", 1, e >= 1 && e <= 5);
        mode_run_raw = 1'b0;
        cyc(20);
        flash();
        chk("slow_to_steady", 0, e);
        mode_run_raw = 1'b1;
        cyc(1);
        mode_run_raw = 1'b0;
        cyc(20);
        chk("bounce_ignored", 1, {run_led, stop_led});
        pulse(self_overall_req);
        mode_run_raw = 1'b1;
        flash();
        chk("pending_fast", 1, e >= 6);
        chk("pending_refuses", 0, run_led);
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        cyc(8);
        rst = 1'b0;
        t_init();
        t_overall();
        t_reset();
        t_int();
        t_faults();
        t_stops();
        end_sim();
    end
    // the run needs some 1160 cycles; four times that means a hang
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
